// [hdl/sdram_pd_pkg.sv]
/*
  Shared types, timing counts and register map for the power-down link.
  Assumes one 100 MHz clock for both ends and a burst length of four.
*/
package sdram_pd_pkg;

  // ****************************************
  // Commands, encoded {cs_n, ras_n, cas_n, we_n}
  // ****************************************
  typedef enum logic [3:0] {
    CMD_LOAD      = 4'h0,
    CMD_REFRESH   = 4'h1,
    CMD_PRECHARGE = 4'h2,
    CMD_ACTIVATE  = 4'h3,
    CMD_WRITE     = 4'h4,
    CMD_READ      = 4'h5,
    CMD_NOP       = 4'h7,
    CMD_DESELECT  = 4'h8
  } cmd_t;

  typedef enum logic [1:0] {
    DEV_ACTIVE   = 2'b00,
    DEV_PRE_PD   = 2'b01,
    DEV_ACT_PD   = 2'b11,
    DEV_SELF_REF = 2'b10
  } dev_state_t;

  typedef enum logic [1:0] {
    CTL_RUN      = 2'b00,
    CTL_PD       = 2'b01,
    CTL_SR       = 2'b10
  } ctl_state_t;

  typedef logic [9:0] cnt_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int   CLK_PERIOD_PS    = 10000;
  localparam int   WR_TIME_PS       = 15000;
  localparam int   WTR_TIME_PS      = 7500;
  localparam int   XSNR_TIME_PS     = 127500;
  localparam int   WTR_RAW          = (WTR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam cnt_t WR_CYC           = cnt_t'((WR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam cnt_t WTR_CYC          = cnt_t'((WTR_RAW > 2) ? WTR_RAW : 2);
  localparam cnt_t XSNR_CYC         = cnt_t'((XSNR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam cnt_t CAS_LAT          = 10'd3;
  localparam cnt_t WRITE_LAT        = 10'd2;
  localparam cnt_t BURST_CLKS       = 10'd2;
  localparam cnt_t POSTAMBLE_CYC    = 10'd1;
  localparam cnt_t READ_DONE_CYC    = CAS_LAT + BURST_CLKS + POSTAMBLE_CYC;
  localparam cnt_t WRITE_DONE_CYC   = WRITE_LAT + BURST_CLKS + WR_CYC;
  localparam cnt_t MIN_CKE_PULSE    = 10'd3;
  localparam cnt_t XP_CYC           = 10'd2;
  localparam cnt_t XARD_CYC         = 10'd2;
  localparam cnt_t XARDS_CYC        = 10'd7;
  localparam cnt_t XSRD_CYC         = 10'd200;
  localparam cnt_t MRD_CYC          = 10'd2;
  localparam cnt_t ENTRY_AFTER_CMD  = 10'd1;
  localparam cnt_t PD_LIMIT_CYC     = 10'd780;

  // ****************************************
  // Address fields and registers
  // ****************************************
  localparam int   A10_BIT          = 10;
  localparam int   MR_SLOW_EXIT_BIT = 12;
  localparam int   MR_WR_LSB        = 9;
  localparam logic [11:0] REG_CMD    = 12'h000;
  localparam logic [11:0] REG_CTRL   = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam int   CTRL_PD_BIT      = 0;
  localparam int   CTRL_SR_BIT      = 1;
  localparam int   CTRL_WAKE_BIT    = 2;
  localparam int   ST_CMD_OK        = 2;
  localparam int   ST_READ_OK       = 3;
  localparam int   ST_REFUSED       = 4;
  localparam int   ST_PEND          = 5;
  localparam int   ST_SLOW          = 6;
  localparam int   ST_BANKS_LSB     = 8;

  function automatic logic is_idle_cmd(input logic [3:0] c);
    return c[3] | (c == CMD_NOP);
  endfunction : is_idle_cmd

  function automatic cnt_t dec_sat(input cnt_t c);
    return (c == 10'd0) ? 10'd0 : c - 10'd1;
  endfunction : dec_sat

  function automatic cnt_t max_cnt(input cnt_t a, input cnt_t b);
    return (a > b) ? a : b;
  endfunction : max_cnt

endpackage : sdram_pd_pkg

// [hdl/sdram_pd_if.sv]
/*
  Command link between the memory controller and the DRAM power-down logic.
  Assumes both ends run on the same clock; the bench joins the two ends.
*/
`timescale 1ns/1ns
interface sdram_pd_if;
  logic        cke;
  logic [3:0]  cmd_n;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic        termination_control;

  modport device     (input  cke, cmd_n, ba, addr, termination_control);
  modport controller (output cke, cmd_n, ba, addr, termination_control);
endinterface : sdram_pd_if

// [hdl/sdram_pd_device.sv]
/*
  DRAM end: follows the clock-enable truth table and reports its mode.
  Assumes the controller keeps its own entry and exit timing.
*/
`timescale 1ns/1ns
module sdram_pd_device
  import sdram_pd_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  sdram_pd_if.device       link,
  output logic [1:0]       o_mode,
  output logic             o_buffers_on,
  output logic             o_dll_frozen,
  output logic             o_refresh_held,
  output logic             o_slow_exit,
  output logic             o_violation
);

  // ****************************************
  // State
  // ****************************************
  dev_state_t  state_ff,  nxt_state;
  logic        cke_prev_ff, nxt_cke_prev;
  logic [7:0]  open_ff,   nxt_open;
  cnt_t        busy_ff,   nxt_busy;
  cnt_t        ap_ff,     nxt_ap;
  logic [2:0]  ap_bank_ff, nxt_ap_bank;
  logic        slow_ff,   nxt_slow;
  logic        viol_ff,   nxt_viol;
  logic        buf_ff,    nxt_buf;
  logic        dll_ff,    nxt_dll;
  logic        held_ff,   nxt_held;

  always_comb begin
    logic idle;
    idle         = is_idle_cmd(link.cmd_n);
    nxt_state    = state_ff;
    nxt_cke_prev = link.cke;
    nxt_open     = open_ff;
    nxt_busy     = dec_sat(busy_ff);
    nxt_ap       = dec_sat(ap_ff);
    nxt_ap_bank  = ap_bank_ff;
    nxt_slow     = slow_ff;
    nxt_viol     = 1'b0;
    // Internal precharge at end of the read burst or of write recovery
    if (ap_ff == 10'd1) begin
      nxt_open[ap_bank_ff] = 1'b0;
    end
    unique case (state_ff)
      DEV_ACTIVE: begin
        if (cke_prev_ff && !link.cke) begin
          if (busy_ff != 10'd0) begin
            nxt_viol = 1'b1;
          end
          if (idle) begin
            nxt_state = (open_ff == 8'h00) ? DEV_PRE_PD : DEV_ACT_PD;
          end else if (link.cmd_n == CMD_REFRESH && open_ff == 8'h00) begin
            nxt_state = DEV_SELF_REF;
          end else begin
            nxt_viol = 1'b1;
          end
        end else if (link.cke) begin
          unique case (link.cmd_n)
            CMD_ACTIVATE:  nxt_open[link.ba] = 1'b1;
            CMD_PRECHARGE: begin
              if (link.addr[A10_BIT]) begin
                nxt_open = 8'h00;
              end else begin
                nxt_open[link.ba] = 1'b0;
              end
            end
            CMD_READ, CMD_WRITE: begin
              nxt_busy = (link.cmd_n == CMD_READ) ? READ_DONE_CYC : WRITE_DONE_CYC;
              if (link.addr[A10_BIT]) begin
                nxt_ap      = nxt_busy;
                nxt_ap_bank = link.ba;
              end
            end
            CMD_LOAD: begin
              if (link.ba == 3'h0) begin
                nxt_slow = link.addr[MR_SLOW_EXIT_BIT];
              end
            end
            default: ;
          endcase
        end
      end
      DEV_PRE_PD, DEV_ACT_PD, DEV_SELF_REF: begin
        // Low keeps the mode; rising needs an idle command
        if (link.cke) begin
          if (idle) begin
            nxt_state = DEV_ACTIVE;
          end else begin
            nxt_viol = 1'b1;
          end
        end
      end
    endcase
    // Only clock, termination and clock enable stay awake
    nxt_buf  = (nxt_state == DEV_ACTIVE);
    nxt_dll  = (nxt_state == DEV_PRE_PD) || (nxt_state == DEV_SELF_REF);
    nxt_held = (nxt_state == DEV_PRE_PD) || (nxt_state == DEV_ACT_PD);
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff    <= DEV_ACTIVE;
      cke_prev_ff <= 1'b0;
      open_ff     <= 8'h00;
      busy_ff     <= 10'h000;
      ap_ff       <= 10'h000;
      ap_bank_ff  <= 3'h0;
      slow_ff     <= 1'b0;
      viol_ff     <= 1'b0;
      buf_ff      <= 1'b1;
      dll_ff      <= 1'b0;
      held_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      cke_prev_ff <= nxt_cke_prev;
      open_ff     <= nxt_open;
      busy_ff     <= nxt_busy;
      ap_ff       <= nxt_ap;
      ap_bank_ff  <= nxt_ap_bank;
      slow_ff     <= nxt_slow;
      viol_ff     <= nxt_viol;
      buf_ff      <= nxt_buf;
      dll_ff      <= nxt_dll;
      held_ff     <= nxt_held;
    end
  end

  assign o_mode         = state_ff;
  assign o_buffers_on   = buf_ff;
  assign o_dll_frozen   = dll_ff;
  assign o_refresh_held = held_ff;
  assign o_slow_exit    = slow_ff;
  assign o_violation    = viol_ff;

endmodule : sdram_pd_device

// [hdl/sdram_pd_ctrl.sv]
/*
  Controller end: issues commands and drives clock enable under APB control.
  Assumes an APB master on the same clock and the DRAM end on the link.
*/
// Notes on behaviour
// - Clock enable stays high through every burst
// - Burst done after postamble and recovery
// - Write-to-read wait is at least two
// - Power-down entry only with idle command
// - No entry during load, read, write, precharge
// - Idle banks precharge, open row active
// - Buffers off, loop frozen in precharge
// - Active exit keeps the entry clock
// - No refresh in power-down, limit time
// - Clock enable holds three edges per level
// - Termination driven low in power-down
// - Exit on high sample with idle command
// - Exit delay before any non-read command
// - Read after active exit: fast or slow
// - No column access at entry time
// - Self refresh only all idle, refresh
// - Self refresh exit: idle, read after 200
// - Entry one clock after read completes
// - Entry one clock after auto precharge
// - Write recovery field rounded up in cycles
// - Entry one clock after activate, refresh, precharge
// - Load only idle; entry after load delay
`timescale 1ns/1ns
module sdram_pd_ctrl
  import sdram_pd_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rstn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  sdram_pd_if.controller   link
);

  // ****************************************
  // State
  // ****************************************
  ctl_state_t  state_ff,  nxt_state;
  logic        cke_ff,    nxt_cke;
  logic [3:0]  cmd_ff,    nxt_cmd;
  logic [2:0]  ba_ff,     nxt_ba;
  logic [13:0] addr_ff,   nxt_addr;
  logic [7:0]  open_ff,   nxt_open;
  cnt_t        entry_ff,  nxt_entry;
  cnt_t        cwait_ff,  nxt_cwait;
  cnt_t        rwait_ff,  nxt_rwait;
  cnt_t        hold_ff,   nxt_hold;
  cnt_t        pdtime_ff, nxt_pdtime;
  logic        actpd_ff,  nxt_actpd;
  logic        slow_ff,   nxt_slow;
  logic        pend_ff,   nxt_pend;
  logic [3:0]  pcmd_ff,   nxt_pcmd;
  logic [2:0]  pba_ff,    nxt_pba;
  logic [13:0] paddr_ff,  nxt_paddr;
  logic [2:0]  req_ff,    nxt_req;
  logic        refused_ff, nxt_refused;
  logic        pready_ff, nxt_pready;
  logic        perr_ff,   nxt_perr;
  logic [31:0] prdata_ff, nxt_prdata;

  // ****************************************
  // Register bus and sequencing
  // ****************************************
  always_comb begin
    logic acc;
    logic wr;
    logic rd_st;
    logic setup;
    logic ok;
    logic refuse;
    acc         = i_psel & i_penable & pready_ff;
    wr          = acc & i_pwrite;
    rd_st       = acc & ~i_pwrite & (i_paddr == REG_STATUS);
    setup       = i_psel & ~i_penable;
    ok          = 1'b0;
    refuse      = 1'b0;
    nxt_state   = state_ff;
    nxt_cke     = cke_ff;
    nxt_cmd     = CMD_NOP;
    nxt_ba      = ba_ff;
    nxt_addr    = addr_ff;
    nxt_open    = open_ff;
    nxt_entry   = dec_sat(entry_ff);
    nxt_cwait   = dec_sat(cwait_ff);
    nxt_rwait   = dec_sat(rwait_ff);
    nxt_hold    = dec_sat(hold_ff);
    nxt_pdtime  = 10'd0;
    nxt_actpd   = actpd_ff;
    nxt_slow    = slow_ff;
    nxt_pend    = pend_ff;
    nxt_pcmd    = pcmd_ff;
    nxt_pba     = pba_ff;
    nxt_paddr   = paddr_ff;
    nxt_req     = req_ff;
    unique case (state_ff)
      CTL_RUN: begin
        if (pend_ff) begin
          // Reads have their own, possibly longer, gate
          ok = (pcmd_ff == CMD_READ) ? (rwait_ff == 10'd0) : (cwait_ff == 10'd0);
          if (pcmd_ff == CMD_READ && cwait_ff != 10'd0 && rwait_ff == 10'd0 && hold_ff != 10'd0) begin
            ok = 1'b1;
          end
          if (pcmd_ff == CMD_LOAD && open_ff != 8'h00) begin
            ok       = 1'b0;
            refuse   = 1'b1;
            nxt_pend = 1'b0;
          end
          if (ok) begin
            nxt_pend  = 1'b0;
            nxt_cmd   = pcmd_ff;
            nxt_ba    = pba_ff;
            nxt_addr  = paddr_ff;
            nxt_cwait = max_cnt(nxt_cwait, 10'd1);
            unique case (pcmd_ff)
              CMD_ACTIVATE: begin
                nxt_open[pba_ff] = 1'b1;
                nxt_entry = max_cnt(nxt_entry, ENTRY_AFTER_CMD);
              end
              CMD_PRECHARGE, CMD_REFRESH: begin
                if (pcmd_ff == CMD_REFRESH || paddr_ff[A10_BIT]) begin
                  nxt_open = (pcmd_ff == CMD_REFRESH) ? open_ff : 8'h00;
                end else begin
                  nxt_open[pba_ff] = 1'b0;
                end
                nxt_entry = max_cnt(nxt_entry, ENTRY_AFTER_CMD);
              end
              CMD_READ: begin
                nxt_entry = max_cnt(nxt_entry, READ_DONE_CYC + 10'd1);
                if (paddr_ff[A10_BIT]) begin
                  nxt_open[pba_ff] = 1'b0;
                end
              end
              CMD_WRITE: begin
                // One clock past write recovery, with or without auto precharge
                nxt_entry = max_cnt(nxt_entry, WRITE_DONE_CYC + 10'd1);
                nxt_rwait = max_cnt(nxt_rwait, WRITE_LAT + BURST_CLKS + WTR_CYC);
                if (paddr_ff[A10_BIT]) begin
                  nxt_open[pba_ff] = 1'b0;
                end
              end
              CMD_LOAD: begin
                if (pba_ff == 3'h0) begin
                  nxt_addr[MR_WR_LSB +: 3] = 3'(WR_CYC - 10'd1);
                  nxt_slow = paddr_ff[MR_SLOW_EXIT_BIT];
                end
                nxt_entry = max_cnt(nxt_entry, MRD_CYC);
                nxt_cwait = max_cnt(nxt_cwait, MRD_CYC);
              end
              default: ;
            endcase
          end
        end else if (req_ff[CTRL_SR_BIT] && open_ff != 8'h00) begin
          nxt_req[CTRL_SR_BIT] = 1'b0;
          refuse = 1'b1;
        end else if ((req_ff[CTRL_PD_BIT] || req_ff[CTRL_SR_BIT]) && entry_ff == 10'd0 &&
                     cwait_ff == 10'd0 && hold_ff == 10'd0) begin
          nxt_cke   = 1'b0;
          nxt_hold  = MIN_CKE_PULSE - 10'd1;
          nxt_actpd = (open_ff != 8'h00);
          nxt_req[CTRL_PD_BIT] = 1'b0;
          nxt_req[CTRL_SR_BIT] = 1'b0;
          if (req_ff[CTRL_SR_BIT]) begin
            nxt_cmd   = CMD_REFRESH;
            nxt_state = CTL_SR;
          end else begin
            nxt_cmd   = CMD_NOP;
            nxt_state = CTL_PD;
          end
        end
        nxt_req[CTRL_WAKE_BIT] = 1'b0;
      end
      CTL_PD, CTL_SR: begin
        // Clock keeps its rate; a wake ends either mode, the refresh limit ends power-down only
        nxt_pdtime = (state_ff == CTL_PD) ? pdtime_ff + 10'd1 : 10'd0;
        if ((req_ff[CTRL_WAKE_BIT] || pdtime_ff >= PD_LIMIT_CYC) && hold_ff == 10'd0) begin
          nxt_cke   = 1'b1;
          nxt_hold  = MIN_CKE_PULSE - 10'd1;
          nxt_state = CTL_RUN;
          nxt_req[CTRL_WAKE_BIT] = 1'b0;
          if (state_ff == CTL_SR) begin
            nxt_cwait = XSNR_CYC;
            nxt_rwait = XSRD_CYC;
          end else begin
            nxt_cwait = XP_CYC;
            nxt_rwait = actpd_ff ? (slow_ff ? XARDS_CYC : XARD_CYC) : XP_CYC;
          end
        end
      end
      default: begin
        nxt_state = CTL_RUN;
        nxt_cke   = 1'b1;
      end
    endcase
    // Bus writes land after sequencing so a late order is still seen
    if (wr && i_paddr == REG_CMD) begin
      if (pend_ff || state_ff != CTL_RUN) begin
        refuse = 1'b1;
      end else begin
        nxt_pend  = 1'b1;
        nxt_pcmd  = i_pwdata[3:0];
        nxt_pba   = i_pwdata[6:4];
        nxt_paddr = i_pwdata[29:16];
      end
    end
    if (wr && i_paddr == REG_CTRL) begin
      nxt_req = nxt_req | i_pwdata[2:0];
    end
    // Refusal sets win over the read that clears them
    nxt_refused = (refused_ff & ~rd_st) | refuse;
    nxt_pready  = setup;
    nxt_perr    = setup & (i_paddr != REG_CMD) & (i_paddr != REG_CTRL) & (i_paddr != REG_STATUS);
    nxt_prdata  = 32'h0000_0000;
    if (setup) begin
      unique case (i_paddr)
        REG_CMD:    nxt_prdata = {2'h0, paddr_ff, 9'h000, pba_ff, pcmd_ff};
        REG_CTRL:   nxt_prdata = {29'h0000_0000, req_ff};
        REG_STATUS: nxt_prdata = {16'h0000, open_ff, 1'b0, slow_ff, pend_ff, refused_ff,
                                  (rwait_ff == 10'd0), (cwait_ff == 10'd0), state_ff};
        default:    nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff   <= CTL_RUN;
      cke_ff     <= 1'b1;
      cmd_ff     <= CMD_NOP;
      ba_ff      <= 3'h0;
      addr_ff    <= 14'h0000;
      open_ff    <= 8'h00;
      entry_ff   <= 10'h000;
      cwait_ff   <= 10'h000;
      rwait_ff   <= 10'h000;
      hold_ff    <= 10'h000;
      pdtime_ff  <= 10'h000;
      actpd_ff   <= 1'b0;
      slow_ff    <= 1'b0;
      pend_ff    <= 1'b0;
      pcmd_ff    <= CMD_NOP;
      pba_ff     <= 3'h0;
      paddr_ff   <= 14'h0000;
      req_ff     <= 3'h0;
      refused_ff <= 1'b0;
      pready_ff  <= 1'b0;
      perr_ff    <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      state_ff   <= nxt_state;
      cke_ff     <= nxt_cke;
      cmd_ff     <= nxt_cmd;
      ba_ff      <= nxt_ba;
      addr_ff    <= nxt_addr;
      open_ff    <= nxt_open;
      entry_ff   <= nxt_entry;
      cwait_ff   <= nxt_cwait;
      rwait_ff   <= nxt_rwait;
      hold_ff    <= nxt_hold;
      pdtime_ff  <= nxt_pdtime;
      actpd_ff   <= nxt_actpd;
      slow_ff    <= nxt_slow;
      pend_ff    <= nxt_pend;
      pcmd_ff    <= nxt_pcmd;
      pba_ff     <= nxt_pba;
      paddr_ff   <= nxt_paddr;
      req_ff     <= nxt_req;
      refused_ff <= nxt_refused;
      pready_ff  <= nxt_pready;
      perr_ff    <= nxt_perr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // Termination is held at a valid low level at all times
  assign link.termination_control   = 1'b0;
  assign link.cke   = cke_ff;
  assign link.cmd_n = cmd_ff;
  assign link.ba    = ba_ff;
  assign link.addr  = addr_ff;
  assign o_prdata   = prdata_ff;
  assign o_pready   = pready_ff;
  assign o_pslverr  = perr_ff;

endmodule : sdram_pd_ctrl

// [tb/sdram_pd_asserts.sv]
/*
  Link checker for the power-down command link and the DRAM end's mode outputs.
  Assumes it is instantiated beside the link interface in tb_top, on one clock.
*/
`timescale 1ns/1ns
module sdram_pd_asserts
  import sdram_pd_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  input wire logic        cke,
  input wire logic [3:0]  cmd_n,
  input wire logic [2:0]  ba,
  input wire logic [13:0] addr,
  input wire logic        termination_control,
  input wire logic [1:0]  o_mode,
  input wire logic        o_buffers_on,
  input wire logic        o_dll_frozen,
  input wire logic        o_violation,
  input wire logic        i_slow_exit
);
  logic idle;
  assign idle = cmd_n[3] | (cmd_n == CMD_NOP);

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  // ****************************************
  // Link timing
  // ****************************************
  cke_hold_a: assert property ($changed(cke) |=> $stable(cke) [*2])
    else $error("clock enable moved before three edges");
  entry_cmd_a: assert property ($fell(cke) |-> idle || cmd_n == CMD_REFRESH)
    else $error("clock enable fell with a bad command");
  exit_cmd_a: assert property ($rose(cke) |-> idle)
    else $error("clock enable rose with a bad command");
  burst_hold_a: assert property (cmd_n == CMD_READ || cmd_n == CMD_WRITE |-> cke [*7])
    else $error("clock enable fell before burst end");
  load_gap_a: assert property (cmd_n == CMD_LOAD |=> cke)
    else $error("entry inside mode load delay");
  sr_exit_idle_a: assert property ($rose(cke) && o_mode == DEV_SELF_REF |=> idle [*8])
    else $error("command inside self refresh exit delay");
  odt_low_a: assert property (!cke |-> !termination_control)
    else $error("termination driven high in power-down");

  // ****************************************
  // Device end
  // ****************************************
  pd_mode_a: assert property ($fell(cke) && idle |=> o_mode inside {DEV_PRE_PD, DEV_ACT_PD})
    else $error("power-down not entered");
  sr_mode_a: assert property ($fell(cke) && cmd_n == CMD_REFRESH |=> o_mode == DEV_SELF_REF)
    else $error("self refresh not entered");
  mode_kept_a: assert property (!cke && o_mode != DEV_ACTIVE |=> $stable(o_mode))
    else $error("mode left while clock enable low");
  wake_mode_a: assert property ($rose(cke) && o_mode != DEV_ACTIVE |=> o_mode == DEV_ACTIVE)
    else $error("power-down not exited");
  buffers_off_a: assert property ($changed(o_mode) |-> o_buffers_on == (o_mode == DEV_ACTIVE))
    else $error("buffers do not follow mode");
  dll_freeze_a: assert property (o_mode == DEV_PRE_PD |-> o_dll_frozen)
    else $error("delay loop running in precharge power-down");
  slow_bit_a: assert property (cke && cmd_n == CMD_LOAD && ba == 3'h0 |=> i_slow_exit == $past(addr[MR_SLOW_EXIT_BIT]))
    else $error("slow exit bit not taken");
  no_violation_a: assert property (!o_violation)
    else $error("device flagged an illegal sequence");

  pd_seen_c: cover property ($fell(cke) && idle);
  sr_seen_c: cover property ($fell(cke) && cmd_n == CMD_REFRESH);
  wake_seen_c: cover property ($rose(cke));
endmodule : sdram_pd_asserts

// [tb/tb_top.sv]
/*
  Testbench: APB orders to the controller end, mode checks on the DRAM end.
  Assumes the package timing and the register map of the controller.
*/
`timescale 1ns/1ns
module tb_top
  import sdram_pd_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rstn    = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  mode;
  logic        buffers_on;
  logic        dll_frozen;
  logic        refresh_held;
  logic        slow_exit;
  logic        violation;
  logic [31:0] rd;
  logic        err;
  int          n_fail   = 0;
  int          n_checks = 0;

  always #5 clk_sys = ~clk_sys;

  sdram_pd_if lnk();
  sdram_pd_ctrl i_sdram_pd_ctrl (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .link(lnk));
  sdram_pd_device i_sdram_pd_device (.i_clk_sys(clk_sys), .i_rstn(rstn), .link(lnk), .o_mode(mode),
    .o_buffers_on(buffers_on), .o_dll_frozen(dll_frozen), .o_refresh_held(refresh_held),
    .o_slow_exit(slow_exit), .o_violation(violation));
  sdram_pd_asserts i_sdram_pd_asserts (.i_clk_sys(clk_sys), .i_rstn(rstn), .cke(lnk.cke), .cmd_n(lnk.cmd_n),
    .ba(lnk.ba), .addr(lnk.addr), .termination_control(lnk.termination_control), .o_mode(mode), .o_buffers_on(buffers_on),
    .o_dll_frozen(dll_frozen), .o_violation(violation), .i_slow_exit(slow_exit));

  task automatic end_of_test;
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // ****************************************
  // APB master: setup, access until pready
  // ****************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  // Polls until the order has left the pending slot
  task automatic issue(input cmd_t c, input logic [2:0] b, input logic [13:0] a);
    int k;
    k = 0;
    apb(1'b1, REG_CMD, {2'b00, a, 9'h000, b, c});
    do begin
      apb(1'b0, REG_STATUS, 32'h0000_0000);
      k++;
    end while (rd[ST_PEND] !== 1'b0 && k < 300);
    if (rd[ST_PEND] !== 1'b0) begin
      n_fail++;
      end_of_test();
    end
  endtask : issue

  task automatic wait_mode(input logic [1:0] exp);
    int k;
    k = 0;
    while (mode !== exp && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    chk("mode", {30'h0, exp}, {30'h0, mode});
    if (mode !== exp) begin
      end_of_test();
    end
  endtask : wait_mode

  initial begin
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    chk("buffers_reset", 32'h1, {31'h0, buffers_on});
    apb(1'b0, 12'hFF0, 32'h0000_0000);
    chk("unmapped_err", 32'h1, {31'h0, err});
    issue(CMD_LOAD, 3'h0, 14'h1000);
    chk("slow_exit", 32'h1, {31'h0, slow_exit});
    issue(CMD_ACTIVATE, 3'h2, 14'h0000);
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("sr_refused", 32'h1, {31'h0, rd[ST_REFUSED]});
    chk("open_banks", 32'h4, {24'h0, rd[15:8]});
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("refused_clear", 32'h0, {31'h0, rd[ST_REFUSED]});
    // Entry ordered right after a read: must wait out the burst
    issue(CMD_READ, 3'h2, 14'h0000);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    wait_mode(DEV_ACT_PD);
    chk("buffers_pd", 32'h0, {31'h0, buffers_on});
    chk("dll_act_pd", 32'h0, {31'h0, dll_frozen});
    chk("refresh_pd", 32'h1, {31'h0, refresh_held});
    apb(1'b1, REG_CMD, {28'h0, CMD_PRECHARGE});
    apb(1'b0, REG_STATUS, 32'h0000_0000);
    chk("cmd_refused", 32'h1, {31'h0, rd[ST_REFUSED]});
    chk("ctl_pd", 32'h1, {30'h0, rd[1:0]});
    // Wake after the refused order: clock enable low time already over
    apb(1'b1, REG_CTRL, 32'h0000_0004);
    wait_mode(DEV_ACTIVE);
    issue(CMD_READ, 3'h2, 14'h0000);
    issue(CMD_WRITE, 3'h2, 14'h0400);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    wait_mode(DEV_PRE_PD);
    chk("dll_pre_pd", 32'h1, {31'h0, dll_frozen});
    apb(1'b1, REG_CTRL, 32'h0000_0004);
    wait_mode(DEV_ACTIVE);
    issue(CMD_LOAD, 3'h0, 14'h0000);
    chk("fast_exit", 32'h0, {31'h0, slow_exit});
    issue(CMD_REFRESH, 3'h0, 14'h0000);
    apb(1'b1, REG_CTRL, 32'h0000_0002);
    wait_mode(DEV_SELF_REF);
    chk("refresh_sr", 32'h0, {31'h0, refresh_held});
    chk("dll_sr", 32'h1, {31'h0, dll_frozen});
    apb(1'b1, REG_CTRL, 32'h0000_0004);
    wait_mode(DEV_ACTIVE);
    issue(CMD_ACTIVATE, 3'h5, 14'h0000);
    issue(CMD_PRECHARGE, 3'h0, 14'h0400);
    apb(1'b1, REG_CTRL, 32'h0000_0001);
    wait_mode(DEV_PRE_PD);
    // No wake order: the duration limit must end power-down
    wait_mode(DEV_ACTIVE);
    end_of_test();
  end
endmodule : tb_top
